// ==== flash_cmd_pkg.sv ====
package flash_cmd_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] MC_BASE = 32'hFFFF_FF60;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h10;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h14;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h18;

  // ****************************************
  // field layout
  // ****************************************
  localparam int MODE_RDY_IE_BIT = 0;
  localparam int WS_LSB = 8;
  localparam int WS_W = 4;
  localparam int KEY_LSB = 24;
  localparam int ARG_LSB = 8;
  localparam int ARG_W = 16;
  localparam int CODE_LSB = 0;
  localparam logic [7:0] CMD_KEY = 8'h5A;
  localparam int ST_READY_BIT = 0;
  localparam int ST_CMDERR_BIT = 1;
  localparam int ST_LOCKERR_BIT = 2;
  localparam int EVT_W = 3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_WP = 8'h12;
  localparam logic [7:0] CMD_WPL = 8'h22;
  localparam logic [7:0] CMD_EWP = 8'h32;
  localparam logic [7:0] CMD_EWPL = 8'h42;
  localparam logic [7:0] CMD_EA = 8'h13;
  localparam logic [7:0] CMD_SLB = 8'h14;
  localparam logic [7:0] CMD_CLB = 8'h24;
  localparam logic [7:0] CMD_GLB = 8'h15;
  localparam logic [7:0] CMD_SGPB = 8'h34;
  localparam logic [7:0] CMD_CGPB = 8'h44;
  localparam logic [7:0] CMD_GGPB = 8'h25;

  typedef enum logic [1:0] {
    IDLE_S = 2'b01,
    BUSY_S = 2'b10
  } seq_state_e;

endpackage

// ==== embedded_flash_cmd_interface.sv ====
// What this block does
// - seven control registers at 0x00..0x18 above base 0xFFFF_FF60
// - mode bit 0 gates the ready condition onto the interrupt line
// - every flash read or write access takes wait count plus one cycles
// - a command write is accepted only with key byte 0x5A
// - a wrongly keyed command write is discarded and starts nothing
// - the operation comes from command bits 7..0
// - bits 23..8 give page number or general-purpose bit number
// - erase-all and query commands ignore the argument
// - status bit 0 is ready, cleared as soon as the controller is busy
// - interrupt asserts while ready is set and its enable is 1
// - bit 1 flags bad key or command; cleared by status read or command write
// - bit 2 flags program or erase into locked region; cleared the same way
// - results come through result register, one word per read
// - after reset mode and result read zero, status reads only ready
// - programming starts at the valid program command, dropping ready then
// - erase touching any locked region is refused whole
module embedded_flash_cmd_interface #(
  parameter int NUM_LOCK = 64,
  parameter int PAGES_PER_LOCK = 16,
  parameter int NUM_GENERAL_PURPOSE_NV_BIT = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // flash array access timing
  input wire logic acc_req,
  output logic acc_done,
  output logic [3:0] wait_state_count,
  // flash engine
  output logic op_start,
  output logic [7:0] op_code,
  output logic [15:0] op_page,
  input wire logic op_done,
  // interrupt
  output logic irq
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
    hit = (a == flash_cmd_pkg::MC_BASE + {24'h00_0000, ofs});
  endfunction

  function automatic logic is_prog(input logic [7:0] c);
    is_prog = (c == flash_cmd_pkg::CMD_WP) || (c == flash_cmd_pkg::CMD_WPL) ||
              (c == flash_cmd_pkg::CMD_EWP) || (c == flash_cmd_pkg::CMD_EWPL);
  endfunction

  function automatic logic is_known(input logic [7:0] c);
    is_known = is_prog(c) || (c == flash_cmd_pkg::CMD_EA) ||
               (c == flash_cmd_pkg::CMD_SLB) || (c == flash_cmd_pkg::CMD_CLB) ||
               (c == flash_cmd_pkg::CMD_GLB) || (c == flash_cmd_pkg::CMD_SGPB) ||
               (c == flash_cmd_pkg::CMD_CGPB) || (c == flash_cmd_pkg::CMD_GGPB);
  endfunction

  function automatic logic [31:0] region_of(input logic [15:0] page);
    region_of = 32'(page) / 32'(PAGES_PER_LOCK);
  endfunction

  localparam int RES_WORDS = (NUM_LOCK + 31) / 32;
  localparam int PTR_W = $clog2(RES_WORDS + 2);

  // ****************************************
  // decode
  // ****************************************
  logic wr_mode, wr_cmd, rd_state, rd_result, wr_evt_en, wr_evt_clr;
  logic [7:0] cmd_key, cmd_code;
  logic [15:0] cmd_arg;
  logic key_ok, code_ok, cmd_accept, cmd_bad;
  logic [31:0] lock_page;
  logic region_locked;

  logic [31:0] mode_ff;
  flash_cmd_pkg::seq_state_e state_ff;
  logic cmd_err_ff, lock_err_ff;
  logic [NUM_LOCK-1:0] lock_bits_ff;
  logic [NUM_GENERAL_PURPOSE_NV_BIT-1:0] general_purpose_nv_bit_ff;
  logic [7:0] cur_code_ff;
  logic [15:0] cur_page_ff;
  logic [1:0] res_src_ff;
  logic [PTR_W-1:0] res_ptr_ff;
  localparam int EVT_W_L = flash_cmd_pkg::EVT_W;
  logic [EVT_W_L-1:0] evt_status_ff, evt_enable_ff;

  assign wr_mode = reg_wr && hit(reg_addr, flash_cmd_pkg::OFS_MODE);
  assign wr_cmd = reg_wr && hit(reg_addr, flash_cmd_pkg::OFS_CMD);
  assign rd_state = reg_rd && hit(reg_addr, flash_cmd_pkg::OFS_STATE);
  assign rd_result = reg_rd && hit(reg_addr, flash_cmd_pkg::OFS_RESULT);
  assign wr_evt_en = reg_wr && hit(reg_addr, flash_cmd_pkg::OFS_EVT_ENABLE);
  assign wr_evt_clr = reg_wr && hit(reg_addr, flash_cmd_pkg::OFS_EVT_CLEAR);

  assign cmd_key = reg_wdata[flash_cmd_pkg::KEY_LSB +: 8];
  assign cmd_code = reg_wdata[flash_cmd_pkg::CODE_LSB +: 8];
  assign cmd_arg = reg_wdata[flash_cmd_pkg::ARG_LSB +: flash_cmd_pkg::ARG_W];
  assign key_ok = (cmd_key == flash_cmd_pkg::CMD_KEY);
  assign code_ok = is_known(cmd_code);
  // a command landing while busy is refused as an error rather than queued
  assign cmd_accept = wr_cmd && key_ok && code_ok && (state_ff == flash_cmd_pkg::IDLE_S);
  assign cmd_bad = wr_cmd && !cmd_accept;

  assign lock_page = region_of(cmd_arg);
  assign region_locked = (lock_page < 32'(NUM_LOCK)) &&
                         lock_bits_ff[lock_page[$clog2(NUM_LOCK)-1:0]];

  // program into a locked region or erase-all with any lock set is refused
  logic lock_refuse;
  assign lock_refuse = cmd_accept &&
    ((is_prog(cmd_code) && region_locked) ||
     (cmd_code == flash_cmd_pkg::CMD_EA && |lock_bits_ff));

  logic ext_start;
  assign ext_start = cmd_accept && !lock_refuse &&
                     (is_prog(cmd_code) || cmd_code == flash_cmd_pkg::CMD_EA);

  // ****************************************
  // mode register
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= flash_cmd_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_ff <= {20'h0_0000, reg_wdata[flash_cmd_pkg::WS_LSB +: flash_cmd_pkg::WS_W],
                  7'h00, reg_wdata[flash_cmd_pkg::MODE_RDY_IE_BIT]};
    end
  end

  assign wait_state_count = mode_ff[flash_cmd_pkg::WS_LSB +: flash_cmd_pkg::WS_W];

  // ****************************************
  // access timing
  // ****************************************
  logic [4:0] acc_cnt_ff;
  logic acc_busy_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_cnt_ff <= 5'h00;
      acc_busy_ff <= 1'b0;
    end else if (!acc_busy_ff && acc_req) begin
      acc_cnt_ff <= {1'b0, wait_state_count};
      acc_busy_ff <= 1'b1;
    end else if (acc_busy_ff) begin
      acc_cnt_ff <= acc_cnt_ff - 5'h01;
      if (acc_cnt_ff == 5'h00) begin
        acc_busy_ff <= 1'b0;
      end
    end
  end

  // done in the last of wait_state_count+1 cycles following the request
  assign acc_done = acc_busy_ff && (acc_cnt_ff == 5'h00);

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= flash_cmd_pkg::IDLE_S;
    end else begin
      unique case (state_ff)
        flash_cmd_pkg::IDLE_S: begin
          if (ext_start) begin
            state_ff <= flash_cmd_pkg::BUSY_S;
          end
        end
        flash_cmd_pkg::BUSY_S: begin
          if (op_done) begin
            state_ff <= flash_cmd_pkg::IDLE_S;
          end
        end
        // an illegal code falls back to idle rather than locking up
        default: begin
          state_ff <= flash_cmd_pkg::IDLE_S;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_start <= 1'b0;
      cur_code_ff <= 8'h00;
      cur_page_ff <= 16'h0000;
    end else begin
      op_start <= ext_start;
      if (ext_start) begin
        cur_code_ff <= cmd_code;
        cur_page_ff <= (cmd_code == flash_cmd_pkg::CMD_EA) ? 16'h0000 : cmd_arg;
      end
    end
  end

  assign op_code = cur_code_ff;
  assign op_page = cur_page_ff;

  // ****************************************
  // lock and general-purpose bits
  // ****************************************
  logic [31:0] done_region;
  assign done_region = region_of(cur_page_ff);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_bits_ff <= '0;
    end else if (cmd_accept && lock_page < 32'(NUM_LOCK) &&
                 cmd_code == flash_cmd_pkg::CMD_SLB) begin
      lock_bits_ff[lock_page[$clog2(NUM_LOCK)-1:0]] <= 1'b1;
    end else if (cmd_accept && lock_page < 32'(NUM_LOCK) &&
                 cmd_code == flash_cmd_pkg::CMD_CLB) begin
      lock_bits_ff[lock_page[$clog2(NUM_LOCK)-1:0]] <= 1'b0;
    end else if (state_ff == flash_cmd_pkg::BUSY_S && op_done &&
                 done_region < 32'(NUM_LOCK) &&
                 (cur_code_ff == flash_cmd_pkg::CMD_WPL ||
                  cur_code_ff == flash_cmd_pkg::CMD_EWPL)) begin
      // a program-and-lock past the last region locks nothing
      lock_bits_ff[done_region[$clog2(NUM_LOCK)-1:0]] <= 1'b1;
    end
  end

  // bit numbers past the implemented count have no effect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      general_purpose_nv_bit_ff <= '0;
    end else if (cmd_accept && 32'(cmd_arg) < 32'(NUM_GENERAL_PURPOSE_NV_BIT)) begin
      if (cmd_code == flash_cmd_pkg::CMD_SGPB) begin
        general_purpose_nv_bit_ff[cmd_arg[$clog2(NUM_GENERAL_PURPOSE_NV_BIT)-1:0]] <= 1'b1;
      end else if (cmd_code == flash_cmd_pkg::CMD_CGPB) begin
        general_purpose_nv_bit_ff[cmd_arg[$clog2(NUM_GENERAL_PURPOSE_NV_BIT)-1:0]] <= 1'b0;
      end
    end
  end

  // ****************************************
  // error flags
  // ****************************************
  // setting wins over the clear caused by the same write or read
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_err_ff <= 1'b0;
    end else if (cmd_bad) begin
      cmd_err_ff <= 1'b1;
    end else if (rd_state || wr_cmd) begin
      cmd_err_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_err_ff <= 1'b0;
    end else if (lock_refuse) begin
      lock_err_ff <= 1'b1;
    end else if (rd_state || wr_cmd) begin
      lock_err_ff <= 1'b0;
    end
  end

  // ****************************************
  // result words
  // ****************************************
  // 0 none, 1 lock bits, 2 general-purpose bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      res_src_ff <= 2'h0;
      res_ptr_ff <= '0;
    end else if (cmd_accept) begin
      res_ptr_ff <= '0;
      if (cmd_code == flash_cmd_pkg::CMD_GLB) begin
        res_src_ff <= 2'h1;
      end else if (cmd_code == flash_cmd_pkg::CMD_GGPB) begin
        res_src_ff <= 2'h2;
      end else begin
        res_src_ff <= 2'h0;
      end
    end else if (rd_result && res_ptr_ff <= PTR_W'(RES_WORDS)) begin
      res_ptr_ff <= res_ptr_ff + PTR_W'(1);
    end
  end

  logic [RES_WORDS*32-1:0] lock_pad;
  logic [31:0] result_word;
  assign lock_pad = (RES_WORDS*32)'(lock_bits_ff);
  always_comb begin
    result_word = flash_cmd_pkg::RESULT_RESET;
    if (res_src_ff == 2'h1 && res_ptr_ff < PTR_W'(RES_WORDS)) begin
      result_word = lock_pad[res_ptr_ff*32 +: 32];
    end else if (res_src_ff == 2'h2 && res_ptr_ff == '0) begin
      result_word = 32'(general_purpose_nv_bit_ff);
    end
  end

  // ****************************************
  // event interrupts
  // ****************************************
  logic ready, ready_q_ff;
  logic [EVT_W_L-1:0] evt_set;
  assign ready = (state_ff == flash_cmd_pkg::IDLE_S);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_q_ff <= 1'b1;
    end else begin
      ready_q_ff <= ready;
    end
  end

  assign evt_set = {lock_refuse, cmd_bad, ready && !ready_q_ff};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_status_ff <= '0;
    end else begin
      evt_status_ff <= evt_set |
        (evt_status_ff & ~(wr_evt_clr ? reg_wdata[EVT_W_L-1:0] : '0));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      evt_enable_ff <= '0;
    end else if (wr_evt_en) begin
      evt_enable_ff <= reg_wdata[EVT_W_L-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (ready && mode_ff[flash_cmd_pkg::MODE_RDY_IE_BIT]) ||
             |(evt_status_ff & evt_enable_ff);
    end
  end

  // ****************************************
  // read data
  // ****************************************
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit(reg_addr, flash_cmd_pkg::OFS_MODE)) begin
      nxt_rdata = mode_ff;
    end else if (hit(reg_addr, flash_cmd_pkg::OFS_STATE)) begin
      nxt_rdata = {29'h0000_0000, lock_err_ff, cmd_err_ff, ready};
    end else if (hit(reg_addr, flash_cmd_pkg::OFS_RESULT)) begin
      nxt_rdata = result_word;
    end else if (hit(reg_addr, flash_cmd_pkg::OFS_EVT_STATUS)) begin
      nxt_rdata = 32'(evt_status_ff);
    end else if (hit(reg_addr, flash_cmd_pkg::OFS_EVT_ENABLE)) begin
      nxt_rdata = 32'(evt_enable_ff);
    end
  end

  // read data stands one cycle only, so a stale word never looks fresh
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// ==== embedded_flash_cmd_interface_properties.sv ====
module flash_cmd_properties #(
  parameter int NUM_LOCK = 64,
  parameter int PAGES_PER_LOCK = 16,
  parameter int NUM_GENERAL_PURPOSE_NV_BIT = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // flash side
  input wire logic acc_req,
  input wire logic acc_done,
  input wire logic [3:0] wait_state_count,
  input wire logic op_start,
  input wire logic [7:0] op_code,
  input wire logic [15:0] op_page,
  input wire logic op_done,
  input wire logic irq
);
  // ****
  // helpers
  // ****
  localparam logic [31:0] CMD_ADDR = flash_cmd_pkg::MC_BASE + 32'(flash_cmd_pkg::OFS_CMD);
  logic [4:0] acc_left_ff;
  logic busy_ff;
  logic cmd_wr;
  assign cmd_wr = reg_wr && reg_addr == CMD_ADDR;
  // mirrors the access timer; the next request waits until this is back at zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_left_ff <= 5'h00;
    end else if (acc_req && acc_left_ff == 5'h00) begin
      acc_left_ff <= {1'b0, wait_state_count} + 5'h01;
    end else if (acc_left_ff != 5'h00) begin
      acc_left_ff <= acc_left_ff - 5'h01;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
    end else if (op_start) begin
      busy_ff <= 1'b1;
    end else if (op_done) begin
      busy_ff <= 1'b0;
    end
  end
  // ****
  // assertions
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  acc_timing_a: assert property (acc_done == (acc_left_ff == 5'h01))
    else $error("access done at wrong cycle");
  ws_follow_a: assert property (reg_wr && reg_addr == flash_cmd_pkg::MC_BASE
    |=> wait_state_count == $past(reg_wdata[11:8])) else $error("wait count not updated");
  key_guard_a: assert property (cmd_wr && reg_wdata[31:24] != 8'h5A |=> !op_start)
    else $error("start after bad key");
  start_cause_a: assert property (op_start |-> $past(cmd_wr)
    && $past(reg_wdata[31:24]) == 8'h5A) else $error("start without keyed write");
  start_fields_a: assert property (op_start |-> op_code == $past(reg_wdata[7:0])
    && op_page == (op_code == flash_cmd_pkg::CMD_EA ? 16'h0000 : $past(reg_wdata[23:8])))
    else $error("start fields wrong");
  busy_refuse_a: assert property (busy_ff |-> !op_start)
    else $error("start while busy");
  fields_hold_a: assert property (!op_start |-> $stable(op_code) && $stable(op_page))
    else $error("operation fields moved");
  unmapped_read_a: assert property (reg_rd && reg_addr[31:8] != 24'hFF_FFFF
    |=> reg_rdata == 32'h0000_0000) else $error("unmapped read not zero");
  start_c: cover property (op_start);
  acc_c: cover property (acc_done);
  irq_c: cover property (busy_ff && op_done ##2 irq);
endmodule

bind embedded_flash_cmd_interface flash_cmd_properties #(
  .NUM_LOCK(NUM_LOCK), .PAGES_PER_LOCK(PAGES_PER_LOCK), .NUM_GENERAL_PURPOSE_NV_BIT(NUM_GENERAL_PURPOSE_NV_BIT)
) flash_cmd_properties_i (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
  .acc_done(acc_done), .wait_state_count(wait_state_count), .op_start(op_start),
  .op_code(op_code), .op_page(op_page), .op_done(op_done), .irq(irq)
);

// ==== embedded_flash_cmd_interface_bench.sv ====
module embedded_flash_cmd_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // signals
  // ****
  `define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
  localparam int PPL = 16;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] reg_addr = 32'h0000_0000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic acc_req = 1'b0;
  logic op_done = 1'b0;
  logic [31:0] reg_rdata;
  logic acc_done;
  logic [3:0] wait_state_count;
  logic op_start;
  logic [7:0] op_code;
  logic [15:0] op_page;
  logic irq;
  logic [15:0] pg;
  logic [3:0] ws;
  logic [7:0] key;
  logic [7:0] pcode [3] = '{flash_cmd_pkg::CMD_WP, flash_cmd_pkg::CMD_EWP, flash_cmd_pkg::CMD_EA};
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int k;
  always #2 clk = ~clk;
  embedded_flash_cmd_interface #(.PAGES_PER_LOCK(PPL)) embedded_flash_cmd_interface_i (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req),
    .acc_done(acc_done), .wait_state_count(wait_state_count), .op_start(op_start),
    .op_code(op_code), .op_page(op_page), .op_done(op_done), .irq(irq)
  );
  // ****
  // tasks
  // ****
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic wr(input logic [7:0] o, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= flash_cmd_pkg::MC_BASE + 32'(o);
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= flash_cmd_pkg::MC_BASE + 32'(o);
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic finish_op();
    @(posedge clk);
    op_done <= 1'b1;
    @(posedge clk);
    op_done <= 1'b0;
  endtask
  function automatic logic [31:0] cmdw(input logic [7:0] c, input logic [15:0] a);
    return {8'h5A, a, c};
  endfunction
  // lock bit of the region holding page p, as seen in result word w
  function automatic logic [31:0] lockw(input logic [15:0] p, input int w);
    int r;
    r = p / PPL;
    return (r / 32 == w) ? 32'h0000_0001 << (r % 32) : 32'h0000_0000;
  endfunction
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(32'h8139));
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    rd(8'h08, 32'h0000_0001);
    rd(8'h0C, 32'h0000_0000);
    `CHK(irq, 1'b0)
    repeat (4) begin
      ws = 4'($urandom);
      wr(8'h00, {20'h0_0000, ws, 8'h01});
      rd(8'h00, {20'h0_0000, ws, 8'h01});
      `CHK(wait_state_count, ws)
      `CHK(irq, 1'b1)
      @(posedge clk);
      acc_req <= 1'b1;
      @(posedge clk);
      acc_req <= 1'b0;
      #1;
      k = 0;
      while (acc_done !== 1'b1 && k < 40) begin
        @(posedge clk);
        #1;
        k++;
      end
      `CHK(k, int'(ws))
    end
    foreach (pcode[i]) begin
      pg = 16'($urandom % 1024);
      wr(8'h04, cmdw(pcode[i], pg));
      `CHK(op_start, 1'b1)
      `CHK(op_code, pcode[i])
      `CHK(op_page, pcode[i] == flash_cmd_pkg::CMD_EA ? 16'h0000 : pg)
      rd(8'h08, 32'h0000_0000);
      `CHK(irq, 1'b0)
      finish_op();
      rd(8'h08, 32'h0000_0001);
      `CHK(irq, 1'b1)
    end
    key = 8'($urandom);
    if (key == 8'h5A) key = 8'hA5;
    wr(8'h04, {key, 16'h0000, flash_cmd_pkg::CMD_WP});
    `CHK(op_start, 1'b0)
    rd(8'h08, 32'h0000_0003);
    rd(8'h08, 32'h0000_0001);
    wr(8'h04, cmdw(8'h00, 16'h0000));
    `CHK(op_start, 1'b0)
    rd(8'h08, 32'h0000_0003);
    wr(8'h04, cmdw(8'h00, 16'h0000));
    pg = 16'($urandom % 1024);
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_SLB, pg));
    rd(8'h08, 32'h0000_0001);
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_GLB, 16'($urandom)));
    rd(8'h0C, lockw(pg, 0));
    rd(8'h0C, lockw(pg, 1));
    rd(8'h0C, 32'h0000_0000);
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_WP, pg));
    `CHK(op_start, 1'b0)
    rd(8'h08, 32'h0000_0005);
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_EA, 16'h0000));
    `CHK(op_start, 1'b0)
    rd(8'h08, 32'h0000_0005);
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_CLB, pg));
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_GLB, 16'h0000));
    rd(8'h0C, 32'h0000_0000);
    k = $urandom % 3;
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_SGPB, 16'(k)));
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_SGPB, 16'h0003));
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_GGPB, 16'($urandom)));
    rd(8'h0C, 32'h0000_0001 << k);
    rd(8'h0C, 32'h0000_0000);
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_CGPB, 16'(k)));
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_GGPB, 16'h0000));
    rd(8'h0C, 32'h0000_0000);
    pg = 16'($urandom % 1024);
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_WPL, pg));
    `CHK(op_code, flash_cmd_pkg::CMD_WPL)
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_WP, 16'h0002));
    `CHK(op_start, 1'b0)
    rd(8'h08, 32'h0000_0002);
    finish_op();
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_GLB, 16'h0000));
    rd(8'h0C, lockw(pg, 0));
    rd(8'h0C, lockw(pg, 1));
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_CLB, pg));
    // offset wraps past the top of the address space
    rd(8'hA0, 32'h0000_0000);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h08, 32'h0000_0001);
    wr(8'h00, 32'h0000_0000);
    wr(8'h18, 32'h0000_0007);
    wr(8'h14, 32'h0000_0001);
    wr(8'h04, {key, 24'h00_0012});
    `CHK(irq, 1'b0)
    wr(8'h04, cmdw(flash_cmd_pkg::CMD_WP, 16'h0001));
    finish_op();
    rd(8'h10, 32'h0000_0003);
    `CHK(irq, 1'b1)
    wr(8'h18, 32'h0000_0001);
    rd(8'h10, 32'h0000_0002);
    `CHK(irq, 1'b0)
    end_sim();
  end
endmodule
